// ===== inc/audio_port_pkg.sv
package audio_port_pkg;
// Overview of operation
// - Strap high: device makes and drives clocks.
// - Strap low: partner supplies bit and frame clocks.
// - Ratio strap: master clock 512 or 256.
// - Slave frame spans 64 or 32 bit clocks.
// - Bit clock synchronous to master clock.
// - Frame phase slip over ten resets codec.
// - Format bits 5-4 pick the framing.
// - Format bits 1-0 pick word length.
// - Format bit 6 picks 64 or 32.
// - One format for all five lines.
// - Analog bit 7 selects mono record.
// - Right-justified: left in high half.
// - Left-justified: left high, starts at edge.
// - MSB with frame edge, captured next rise.
// - I2S: left channel in low half.
// - I2S inputs sampled on rising edge.
// - I2S outputs change on falling edge.
// - Mono, side clear: input B left both; code takes the selected input's left.
// - Mono, side set: input B right both; code takes the selected input's right.
// - Analog bit picks input A or B.

    typedef logic [23:0] word_t;
    typedef logic [5:0] slot_t;
    typedef enum logic [1:0] {JUST_LEFT, JUST_RIGHT, JUST_I2S, JUST_NONE} just_t;

    // Device register map
    localparam logic [7:0] FMT_OFFSET = 8'h01;
    localparam logic [7:0] ANA_OFFSET = 8'h02;
    localparam logic [7:0] FMT_RESET = 8'h40;
    localparam logic [7:0] ANA_RESET = 8'h00;
    localparam int RATE_BIT = 6;
    localparam int JUST_HI = 5;
    localparam int JUST_LO = 4;
    localparam int LEN_HI = 1;
    localparam int LEN_LO = 0;
    localparam int MONO_BIT = 7;
    localparam int SIDE_BIT = 6;
    localparam int SRC_BIT = 1;

    // Host controller register map, word indices of byte offsets
    localparam logic [5:0] CTRL_IDX = 6'h00;
    localparam logic [5:0] HFMT_IDX = 6'h01;
    localparam logic [5:0] TX_IDX = 6'h02;
    localparam logic [5:0] RX_IDX = 6'h06;
    localparam logic [5:0] STAT_IDX = 6'h0c;
    localparam int TX_N = 4;
    localparam int RX_N = 6;
    localparam int CTRL_MS_BIT = 0;
    localparam int CTRL_RATIO_BIT = 1;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // Framing
    localparam slot_t WORD_W = 6'd24;
    localparam slot_t HALF_WIDE = 6'd32;
    localparam slot_t HALF_NARROW = 6'd16;
    localparam slot_t LEN_16 = 6'd16;
    localparam slot_t LEN_18 = 6'd18;
    localparam slot_t LEN_20 = 6'd20;
    localparam slot_t LEN_24 = 6'd24;
    localparam slot_t I2S_FIRST = 6'd1;
    localparam slot_t JUST_FIRST = 6'd0;
    localparam slot_t TOP_BIT = 6'd23;

    // Timing
    localparam int SYS_HZ = 40_000_000;
    localparam int BCLK_MAX_HZ = 3_072_000;
    localparam int RATIO_HI = 512;
    localparam int RATIO_LO = 256;
    localparam int MCLK_PER_BCLK_HI = RATIO_HI / 64;
    // Fastest master clock is half the system clock, so the bit clock is
    // 16 cycles (2.5 MHz), inside the bit clock limit.
    localparam int BCLK_MIN_HALF = (SYS_HZ + 2 * BCLK_MAX_HZ - 1)
        / (2 * BCLK_MAX_HZ);
    localparam int BCLK_HALF = MCLK_PER_BCLK_HI;
    localparam int DIV_W = $clog2(2 * BCLK_HALF);
    localparam int BCLK_TAP = DIV_W - 1;
    localparam int MCLK_HI_TAP = 0;
    localparam int MCLK_LO_TAP = 1;
    localparam logic [11:0] SLIP_TOL = 12'd10;

    function automatic just_t just_of(logic [7:0] f);
        return just_t'(f[JUST_HI:JUST_LO]);
    endfunction : just_of

    function automatic slot_t half_len(logic [7:0] f);
        return f[RATE_BIT] ? HALF_WIDE : HALF_NARROW;
    endfunction : half_len

    function automatic slot_t word_len(logic [7:0] f);
        slot_t n;
        unique case (f[LEN_HI:LEN_LO])
            2'b00: n = LEN_16;
            2'b01: n = LEN_18;
            2'b10: n = LEN_20;
            2'b11: n = LEN_24;
        endcase
        return n;
    endfunction : word_len

    function automatic slot_t first_slot(logic [7:0] f);
        slot_t n;
        unique case (just_of(f))
            JUST_RIGHT: n = slot_t'(half_len(f) - word_len(f));
            JUST_I2S: n = I2S_FIRST;
            default: n = JUST_FIRST;
        endcase
        return n;
    endfunction : first_slot

    function automatic logic left_half(logic [7:0] f, logic lvl);
        return (just_of(f) == JUST_I2S) ? !lvl : lvl;
    endfunction : left_half

    function automatic logic in_word(logic [7:0] f, slot_t s);
        return s >= first_slot(f) && s < slot_t'(first_slot(f) + word_len(f));
    endfunction : in_word

    function automatic slot_t last_slot(logic [7:0] f);
        return slot_t'(first_slot(f) + word_len(f) - 6'd1);
    endfunction : last_slot

    function automatic logic [4:0] bit_sel(logic [7:0] f, slot_t s);
        return 5'(TOP_BIT - slot_t'(s - first_slot(f)));
    endfunction : bit_sel

    function automatic word_t align(logic [7:0] f, word_t w);
        return w << slot_t'(WORD_W - word_len(f));
    endfunction : align

    function automatic slot_t mclk_per_bit(logic [7:0] f, logic hi);
        return slot_t'((hi ? RATIO_HI : RATIO_LO) / (2 * int'(half_len(f))));
    endfunction : mclk_per_bit
endpackage : audio_port_pkg

// ===== inc/audio_link_if.sv
`timescale 1ns/1ps
interface audio_link_if;
    logic master_slave_select;
    logic clock_ratio_select;
    logic crystal_or_clock_in;
    logic master_clock_out;
    logic dev_bclk;
    logic dev_bclk_oe;
    logic host_bclk;
    logic host_bclk_oe;
    logic bit_clock;
    logic dev_fclk;
    logic dev_fclk_oe;
    logic host_fclk;
    logic host_fclk_oe;
    logic frame_clock;
    logic serial_in_one;
    logic serial_in_two;
    logic processed_serial_out;
    logic mono_mix_serial_out;
    logic record_serial_out;

    // Device drive wins; a pin nobody drives reads low
    assign bit_clock = dev_bclk_oe ? dev_bclk : (host_bclk_oe & host_bclk);
    assign frame_clock = dev_fclk_oe ? dev_fclk : (host_fclk_oe & host_fclk);

    modport dev_end (
        input master_slave_select, clock_ratio_select, crystal_or_clock_in,
        input bit_clock, frame_clock, serial_in_one, serial_in_two,
        output master_clock_out, dev_bclk, dev_bclk_oe, dev_fclk,
        output dev_fclk_oe, processed_serial_out, mono_mix_serial_out,
        output record_serial_out
    );
    modport host_end (
        output master_slave_select, clock_ratio_select, crystal_or_clock_in,
        output host_bclk, host_bclk_oe, host_fclk, host_fclk_oe,
        output serial_in_one, serial_in_two,
        input master_clock_out, bit_clock, frame_clock,
        input processed_serial_out, mono_mix_serial_out, record_serial_out
    );
endinterface : audio_link_if

// ===== verilog/audio_port_device.sv
// Design decision made here: a simple write-strobe register port, not APB.
`timescale 1ns/1ps
module audio_port_device (
    input wire logic clock,
    input wire logic rst,
    audio_link_if.dev_end link,
    input wire logic ctrl_we,
    input wire logic [7:0] ctrl_addr,
    input wire logic [7:0] ctrl_wdata,
    output logic [7:0] ctrl_rdata,
    input wire audio_port_pkg::word_t proc_left,
    input wire audio_port_pkg::word_t proc_right,
    input wire audio_port_pkg::word_t mix_left,
    input wire audio_port_pkg::word_t mix_right,
    input wire audio_port_pkg::word_t adc_a_left,
    input wire audio_port_pkg::word_t adc_a_right,
    input wire audio_port_pkg::word_t adc_b_left,
    input wire audio_port_pkg::word_t adc_b_right,
    output audio_port_pkg::word_t in_one_left,
    output audio_port_pkg::word_t in_one_right,
    output audio_port_pkg::word_t in_two_left,
    output audio_port_pkg::word_t in_two_right,
    output logic rx_valid,
    output logic codec_reset
);
    ////////////////////////////////////////////////////////////////////////
    logic [1:0] ms_s, ratio_s, bclk_s, fclk_s, din1_s, din2_s;
    logic [7:0] fmt_r, ana_r;

    always_ff @(posedge clock) begin
        ms_s <= {ms_s[0], link.master_slave_select};
        ratio_s <= {ratio_s[0], link.clock_ratio_select};
        bclk_s <= {bclk_s[0], link.bit_clock};
        fclk_s <= {fclk_s[0], link.frame_clock};
        din1_s <= {din1_s[0], link.serial_in_one};
        din2_s <= {din2_s[0], link.serial_in_two};
    end

    wire master = ms_s[1];
    wire ratio_hi = ratio_s[1];

    ////////////////////////////////////////////////////////////////////////
    wire fmt_hit = ctrl_addr == audio_port_pkg::FMT_OFFSET;
    wire ana_hit = ctrl_addr == audio_port_pkg::ANA_OFFSET;
    wire [7:0] rd_w = fmt_hit ? fmt_r : (ana_hit ? ana_r : 8'h00);

    always_ff @(posedge clock) begin
        if (rst) begin
            fmt_r <= audio_port_pkg::FMT_RESET;
            ana_r <= audio_port_pkg::ANA_RESET;
            ctrl_rdata <= 8'h00;
        end else begin
            if (ctrl_we && fmt_hit) begin
                fmt_r <= ctrl_wdata;
            end
            if (ctrl_we && ana_hit) begin
                ana_r <= ctrl_wdata;
            end
            ctrl_rdata <= rd_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [audio_port_pkg::DIV_W-1:0] div_r;
    logic gen_fclk_r, bclk_d_r;
    audio_port_pkg::slot_t slot_r;
    logic side_r, lock_r;

    wire bclk_lvl = master ? div_r[audio_port_pkg::BCLK_TAP] : bclk_s[1];
    wire fclk_lvl = master ? gen_fclk_r : fclk_s[1];
    wire rise = bclk_lvl & ~bclk_d_r;
    wire fall = ~bclk_lvl & bclk_d_r;

    wire audio_port_pkg::slot_t half = audio_port_pkg::half_len(fmt_r);
    wire new_half = fclk_lvl != side_r;
    wire audio_port_pkg::slot_t seen = 6'(slot_r + 6'd1);
    wire audio_port_pkg::slot_t cur_slot = new_half ? 6'd0 : seen;

    wire audio_port_pkg::slot_t dev = (seen > half) ? 6'(seen - half)
        : 6'(half - seen);
    wire [11:0] slip = {6'd0, dev}
        * {6'd0, audio_port_pkg::mclk_per_bit(fmt_r, ratio_hi)};
    wire slipped = lock_r && !master && new_half
        && slip > audio_port_pkg::SLIP_TOL;

    always_ff @(posedge clock) begin
        if (rst) begin
            div_r <= '0;
            bclk_d_r <= 1'b0;
            slot_r <= '0;
            side_r <= 1'b0;
            lock_r <= 1'b0;
            codec_reset <= 1'b0;
        end else begin
            div_r <= div_r + 1'b1;
            bclk_d_r <= bclk_lvl;
            codec_reset <= rise && slipped;
            if (rise) begin
                slot_r <= cur_slot;
                side_r <= fclk_lvl;
                lock_r <= (lock_r | new_half) & ~slipped;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive: the bit of each slot inside the word is taken on the rising bit clock
    audio_port_pkg::word_t sh1_r, sh2_r;
    wire take = rise && audio_port_pkg::in_word(fmt_r, cur_slot);
    wire done = take && cur_slot == audio_port_pkg::last_slot(fmt_r);
    wire audio_port_pkg::word_t nx1 = {sh1_r[22:0], din1_s[1]};
    wire audio_port_pkg::word_t nx2 = {sh2_r[22:0], din2_s[1]};
    wire left_now = audio_port_pkg::left_half(fmt_r, fclk_lvl);

    always_ff @(posedge clock) begin
        if (rst) begin
            sh1_r <= '0;
            sh2_r <= '0;
            in_one_left <= '0;
            in_one_right <= '0;
            in_two_left <= '0;
            in_two_right <= '0;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= done && !left_now && lock_r;
            if (take) begin
                sh1_r <= nx1;
                sh2_r <= nx2;
            end
            if (done && left_now) begin
                in_one_left <= audio_port_pkg::align(fmt_r, nx1);
                in_two_left <= audio_port_pkg::align(fmt_r, nx2);
            end
            if (done && !left_now) begin
                in_one_right <= audio_port_pkg::align(fmt_r, nx1);
                in_two_right <= audio_port_pkg::align(fmt_r, nx2);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit: slot after the current one is launched on the falling edge
    wire wrap = slot_r == 6'(half - 6'd1);
    wire audio_port_pkg::slot_t nslot = wrap ? 6'd0 : seen;
    wire nside = wrap ? ~side_r : side_r;
    wire nleft = audio_port_pkg::left_half(fmt_r, nside);
    wire send = audio_port_pkg::in_word(fmt_r, nslot);
    wire [4:0] pos = audio_port_pkg::bit_sel(fmt_r, nslot);

    wire src_b = ana_r[audio_port_pkg::SRC_BIT];
    wire audio_port_pkg::word_t src_l = src_b ? adc_b_left : adc_a_left;
    wire audio_port_pkg::word_t src_r = src_b ? adc_b_right : adc_a_right;
    wire audio_port_pkg::word_t pick = ana_r[audio_port_pkg::SIDE_BIT]
        ? src_r : src_l;
    wire mono = ana_r[audio_port_pkg::MONO_BIT];
    wire audio_port_pkg::word_t rec_l = mono ? pick : src_l;
    wire audio_port_pkg::word_t rec_r = mono ? pick : src_r;

    audio_port_pkg::word_t pl_r, pr_r, ml_r, mr_r, rl_r, rr_r;
    wire audio_port_pkg::word_t p_w = nleft ? pl_r : pr_r;
    wire audio_port_pkg::word_t m_w = nleft ? ml_r : mr_r;
    wire audio_port_pkg::word_t r_w = nleft ? rl_r : rr_r;

    // A word is refreshed only while the other half is on the wire, so it
    // never changes in the middle of its own shift.
    always_ff @(posedge clock) begin
        if (rst) begin
            {pl_r, pr_r, ml_r, mr_r, rl_r, rr_r} <= '0;
        end else if (fall && wrap && nleft) begin
            pr_r <= proc_right;
            mr_r <= mix_right;
            rr_r <= rec_r;
        end else if (fall && wrap) begin
            pl_r <= proc_left;
            ml_r <= mix_left;
            rl_r <= rec_l;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            gen_fclk_r <= 1'b0;
            link.processed_serial_out <= 1'b0;
            link.mono_mix_serial_out <= 1'b0;
            link.record_serial_out <= 1'b0;
        end else if (fall) begin
            if (wrap) begin
                gen_fclk_r <= ~gen_fclk_r;
            end
            link.processed_serial_out <= send && p_w[pos];
            link.mono_mix_serial_out <= send && m_w[pos];
            link.record_serial_out <= send && r_w[pos];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            link.master_clock_out <= 1'b0;
            link.dev_bclk <= 1'b0;
            link.dev_fclk <= 1'b0;
            link.dev_bclk_oe <= 1'b0;
            link.dev_fclk_oe <= 1'b0;
        end else begin
            link.master_clock_out <= ratio_hi
                ? div_r[audio_port_pkg::MCLK_HI_TAP]
                : div_r[audio_port_pkg::MCLK_LO_TAP];
            link.dev_bclk <= div_r[audio_port_pkg::BCLK_TAP];
            link.dev_fclk <= gen_fclk_r;
            link.dev_bclk_oe <= master;
            link.dev_fclk_oe <= master;
        end
    end
endmodule : audio_port_device

// ===== verilog/audio_port_host.sv
`timescale 1ns/1ps
module audio_port_host (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    audio_link_if.host_end link
);
    ////////////////////////////////////////////////////////////////////////
    logic [2:0] ctrl_r;
    logic [7:0] fmt_r;
    audio_port_pkg::word_t tx_r [audio_port_pkg::TX_N];
    audio_port_pkg::word_t rx_r [audio_port_pkg::RX_N];
    logic [15:0] frames_r;

    wire [5:0] widx = paddr[7:2];
    wire [5:0] tx_off = 6'(widx - audio_port_pkg::TX_IDX);
    wire [5:0] rx_off = 6'(widx - audio_port_pkg::RX_IDX);
    wire is_ctrl = widx == audio_port_pkg::CTRL_IDX;
    wire is_fmt = widx == audio_port_pkg::HFMT_IDX;
    wire is_tx = widx >= audio_port_pkg::TX_IDX
        && tx_off < 6'(audio_port_pkg::TX_N);
    wire is_rx = widx >= audio_port_pkg::RX_IDX
        && rx_off < 6'(audio_port_pkg::RX_N);
    wire is_stat = widx == audio_port_pkg::STAT_IDX;
    wire hit = is_ctrl | is_fmt | is_tx | is_rx | is_stat;
    wire [31:0] rd_w = is_ctrl ? 32'(ctrl_r) : is_fmt ? 32'(fmt_r)
        : is_tx ? 32'(tx_r[tx_off[1:0]]) : is_rx ? 32'(rx_r[rx_off[2:0]])
        : is_stat ? 32'(frames_r) : 32'h0000_0000;
    // One wait state: the answer is armed in the first access cycle
    wire arm = psel && penable && !pready;
    wire wr = psel && penable && pready && pwrite && hit;

    always_ff @(posedge clock) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            ctrl_r <= audio_port_pkg::CTRL_RESET;
            fmt_r <= audio_port_pkg::FMT_RESET;
            for (int i = 0; i < audio_port_pkg::TX_N; i++) begin
                tx_r[i] <= '0;
            end
        end else begin
            pready <= arm;
            pslverr <= arm && !hit;
            if (arm) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_w;
            end
            if (wr && is_ctrl) begin
                ctrl_r <= pwdata[2:0];
            end
            if (wr && is_fmt) begin
                fmt_r <= pwdata[7:0];
            end
            if (wr && is_tx) begin
                tx_r[tx_off[1:0]] <= pwdata[23:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [1:0] bclk_s, fclk_s, d0_s, d1_s, d2_s;
    always_ff @(posedge clock) begin
        bclk_s <= {bclk_s[0], link.bit_clock};
        fclk_s <= {fclk_s[0], link.frame_clock};
        d0_s <= {d0_s[0], link.processed_serial_out};
        d1_s <= {d1_s[0], link.mono_mix_serial_out};
        d2_s <= {d2_s[0], link.record_serial_out};
    end

    logic [audio_port_pkg::DIV_W-1:0] div_r;
    logic gen_fclk_r, bclk_d_r, side_r;
    audio_port_pkg::slot_t slot_r;
    wire drive = !ctrl_r[audio_port_pkg::CTRL_MS_BIT];
    wire bclk_lvl = drive ? div_r[audio_port_pkg::BCLK_TAP] : bclk_s[1];
    wire fclk_lvl = drive ? gen_fclk_r : fclk_s[1];
    wire rise = bclk_lvl & ~bclk_d_r;
    wire fall = ~bclk_lvl & bclk_d_r;
    wire audio_port_pkg::slot_t half = audio_port_pkg::half_len(fmt_r);
    wire new_half = fclk_lvl != side_r;
    wire audio_port_pkg::slot_t seen = 6'(slot_r + 6'd1);
    wire audio_port_pkg::slot_t cur = new_half ? 6'd0 : seen;
    wire wrap = slot_r == 6'(half - 6'd1);
    wire audio_port_pkg::slot_t nslot = wrap ? 6'd0 : seen;
    wire nleft = audio_port_pkg::left_half(fmt_r, wrap ? ~side_r : side_r);
    wire left_now = audio_port_pkg::left_half(fmt_r, fclk_lvl);
    wire take = rise && audio_port_pkg::in_word(fmt_r, cur);
    wire done = take && cur == audio_port_pkg::last_slot(fmt_r);
    wire send = audio_port_pkg::in_word(fmt_r, nslot);
    wire [4:0] pos = audio_port_pkg::bit_sel(fmt_r, nslot);
    wire [2:0] ins = {d2_s[1], d1_s[1], d0_s[1]};
    wire [2:0] base = left_now ? 3'd0 : 3'd3;
    audio_port_pkg::word_t sh_r [3];

    always_ff @(posedge clock) begin
        if (rst) begin
            div_r <= '0;
            bclk_d_r <= 1'b0;
            slot_r <= '0;
            side_r <= 1'b0;
            frames_r <= 16'h0000;
            for (int i = 0; i < 3; i++) begin
                sh_r[i] <= '0;
            end
            for (int i = 0; i < audio_port_pkg::RX_N; i++) begin
                rx_r[i] <= '0;
            end
        end else begin
            div_r <= div_r + 1'b1;
            bclk_d_r <= bclk_lvl;
            if (rise) begin
                slot_r <= cur;
                side_r <= fclk_lvl;
            end
            for (int i = 0; i < 3; i++) begin
                if (take) begin
                    sh_r[i] <= {sh_r[i][22:0], ins[i]};
                end
                if (done) begin
                    rx_r[3'(base + 3'(i))] <= audio_port_pkg::align(fmt_r,
                        {sh_r[i][22:0], ins[i]});
                end
            end
            if (done && !left_now) begin
                frames_r <= frames_r + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    wire audio_port_pkg::word_t w1 = nleft ? tx_r[0] : tx_r[1];
    wire audio_port_pkg::word_t w2 = nleft ? tx_r[2] : tx_r[3];

    always_ff @(posedge clock) begin
        if (rst) begin
            gen_fclk_r <= 1'b0;
            link.serial_in_one <= 1'b0;
            link.serial_in_two <= 1'b0;
            link.master_slave_select <= 1'b0;
            link.clock_ratio_select <= 1'b0;
            link.crystal_or_clock_in <= 1'b0;
            link.host_bclk <= 1'b0;
            link.host_fclk <= 1'b0;
            link.host_bclk_oe <= 1'b0;
            link.host_fclk_oe <= 1'b0;
        end else begin
            if (fall && wrap) begin
                gen_fclk_r <= ~gen_fclk_r;
            end
            if (fall) begin
                link.serial_in_one <= send && w1[pos];
                link.serial_in_two <= send && w2[pos];
            end
            link.master_slave_select <= ctrl_r[audio_port_pkg::CTRL_MS_BIT];
            link.clock_ratio_select <= ctrl_r[audio_port_pkg::CTRL_RATIO_BIT];
            // master clock locked to bit clock
            link.crystal_or_clock_in <= ctrl_r[audio_port_pkg::CTRL_RATIO_BIT]
                ? div_r[audio_port_pkg::MCLK_HI_TAP]
                : div_r[audio_port_pkg::MCLK_LO_TAP];
            link.host_bclk <= div_r[audio_port_pkg::BCLK_TAP];
            link.host_fclk <= gen_fclk_r;
            link.host_bclk_oe <= drive;
            link.host_fclk_oe <= drive;
        end
    end
endmodule : audio_port_host

// ===== dv/audio_link_checker.sv
`timescale 1ns/1ps
module audio_link_checker (
    input wire logic clock,
    input wire logic rst,
    input wire logic master_slave_select,
    input wire logic clock_ratio_select,
    input wire logic master_clock_out,
    input wire logic dev_bclk_oe,
    input wire logic dev_fclk_oe,
    input wire logic bit_clock,
    input wire logic frame_clock,
    input wire logic record_serial_out
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Settled master drive; skips the cycle the enable turns on
    sequence dev_master;
        master_slave_select && dev_bclk_oe && $past(dev_bclk_oe);
    endsequence
    sequence strap_low;
        !master_slave_select [*6];
    endsequence
    a_clocks_driven: assert property ($rose(master_slave_select) |->
        ##[1:6] dev_bclk_oe && dev_fclk_oe) else $error("clocks not driven");
    a_pins_released: assert property (strap_low |->
        !dev_bclk_oe && !dev_fclk_oe) else $error("clock pins still driven");
    a_enables_paired: assert property (dev_bclk_oe == dev_fclk_oe)
        else $error("clock enables differ");
    a_mclk_running: assert property (dev_master |->
        ##[1:2] $changed(master_clock_out)) else $error("master clock idle");
    a_mclk_ratio_low: assert property (dev_master ##0 !clock_ratio_select
        ##0 $changed(master_clock_out) |=> $stable(master_clock_out)
        ##1 $changed(master_clock_out)) else $error("master clock period");
    a_bclk_half: assert property (dev_master ##0 $rose(bit_clock) |=>
        $stable(bit_clock) [*7] ##1 $fell(bit_clock))
        else $error("bit clock half period");
    a_frame_at_fall: assert property (dev_master
        ##0 $changed(frame_clock) |-> !bit_clock)
        else $error("frame edge off bit clock fall");
    a_data_at_fall: assert property (dev_master
        ##0 $changed(record_serial_out) |-> !bit_clock)
        else $error("record data moved while bit clock high");
endmodule : audio_link_checker

// ===== dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, e;
    logic ctrl_we = 0, rx_valid, pready, pslverr, cr;
    logic [7:0] paddr = 8'h00, ctrl_addr = 8'h00, ctrl_wdata = 8'h00;
    logic [7:0] ctrl_rdata, f;
    logic [31:0] pwdata = 32'h0, prdata, q, q0;
    audio_port_pkg::word_t wv [0:12], rv [0:3], m;
    int n_mismatch = 0, n_tests = 0, n_cr = 0, cr0;
    logic [7:0] fm [5] = '{8'h40, 8'h53, 8'h62, 8'h51, 8'h00};
    logic [7:0] an [3] = '{8'h02, 8'h82, 8'hc2};
    int el [3] = '{7, 7, 8}, er [3] = '{8, 7, 8}, ln [4] = '{16, 18, 20, 24};
    audio_link_if link ();
    audio_port_host audio_port_host_inst (.clock, .rst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link);
    audio_port_device audio_port_device_inst (.clock, .rst, .link, .ctrl_we,
        .ctrl_addr, .ctrl_wdata, .ctrl_rdata, .proc_left(wv[1]),
        .proc_right(wv[2]), .mix_left(wv[3]), .mix_right(wv[4]),
        .adc_a_left(wv[5]), .adc_a_right(wv[6]), .adc_b_left(wv[7]),
        .adc_b_right(wv[8]), .in_one_left(rv[0]), .in_one_right(rv[1]),
        .in_two_left(rv[2]), .in_two_right(rv[3]), .rx_valid,
        .codec_reset(cr));
    // Counts slip pulses from the device
    always @(posedge clock) if (cr === 1'b1) n_cr++;
    audio_link_checker audio_link_checker_inst (.clock, .rst,
        .master_slave_select(link.master_slave_select),
        .clock_ratio_select(link.clock_ratio_select),
        .master_clock_out(link.master_clock_out),
        .dev_bclk_oe(link.dev_bclk_oe), .dev_fclk_oe(link.dev_fclk_oe),
        .bit_clock(link.bit_clock), .frame_clock(link.frame_clock),
        .record_serial_out(link.record_serial_out));
    initial begin
        forever #12.5 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("mismatches %0d of %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int i = 0;
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1;
        // Wait state count is the slave's business; bound it only
        do begin @(posedge clock); i++; end while (pready !== 1'b1 && i < 50);
        if (i >= 50) begin n_mismatch++; end_of_test(); end
        q = prdata; e = pslverr;
        psel <= 0; penable <= 0;
        @(posedge clock);
    endtask : apb
    task automatic dw(input logic [7:0] a, input logic [7:0] d);
        ctrl_we <= 1; ctrl_addr <= a; ctrl_wdata <= d;
        @(posedge clock);
        ctrl_we <= 0;
        @(posedge clock);
    endtask : dw
    task automatic dr(input logic [7:0] a, input logic [7:0] x);
        ctrl_addr <= a;
        repeat (2) @(posedge clock);
        chk({24'h0, ctrl_rdata}, {24'h0, x});
    endtask : dr
    task automatic frames(input int n);
        int c = 0, i = 0;
        while (c < n && i < 8000 * n) begin
            @(posedge clock); i++;
            if (rx_valid === 1'b1) c++;
        end
        if (c < n) begin n_mismatch++; end_of_test(); end
    endtask : frames
    ////////////////////////////////////////////////////////////////////////
    initial begin
        for (int k = 0; k < 13; k++) wv[k] = 24'h35a9c6 ^ (24'h10f0e1 * k);
        repeat (8) @(posedge clock);
        rst <= 0;
        @(posedge clock);
        dr(8'h01, 8'h40); dr(8'h02, 8'h00);
        dw(8'h07, 8'h5a); dr(8'h07, 8'h00);
        apb(1, 8'h00, 32'h1); apb(0, 8'h40, 32'h0);
        chk({e, q[30:0]}, 32'h80000000);
        for (int k = 0; k < 4; k++) apb(1, 8'(8 + 4 * k), {8'h0, wv[9 + k]});
        foreach (fm[i]) begin
            f = fm[i]; m = 24'hffffff << (24 - ln[f[1:0]]);
            dw(8'h01, f); apb(1, 8'h04, {24'h0, f}); dr(8'h01, f);
            frames(3);
            for (int k = 0; k < 4; k++) chk(rv[k], wv[9 + k] & m);
            for (int j = 0; j < 6; j++) begin
                apb(0, 8'(24 + 4 * j), 32'h0);
                chk(q, wv[j < 3 ? 1 + 2 * j : 2 * j - 4] & m);
            end
        end
        for (int i = 0; i < 3; i++) begin
            dw(8'h02, an[i]); dr(8'h02, an[i]); frames(3);
            apb(0, 8'h20, 32'h0); chk(q, wv[el[i]] & m);
            apb(0, 8'h2c, 32'h0); chk(q, wv[er[i]] & m);
        end
        apb(1, 8'h00, 32'h2); frames(4);
        chk(rv[0], wv[9] & m); apb(0, 8'h2c, 32'h0); chk(q, wv[8] & m);
        apb(0, 8'h30, 32'h0); q0 = q; frames(2);
        apb(0, 8'h30, 32'h0); chk(q - q0, 2);
        // Steady slave frames must not slip; a 32 bit half against 16 must
        cr0 = n_cr; repeat (2100) @(posedge clock);
        chk(n_cr - cr0, 0);
        apb(1, 8'h04, 32'h40); repeat (2100) @(posedge clock);
        chk(n_cr == cr0, 0);
        end_of_test();
    end
endmodule : tb_top
